// File: rtl/edge_detect.v
`timescale 1ns/100ps
// synchronises one external request pin and flags selected edges
module edge_detect (
   input  wire       mclk_i,
   input  wire       rst_i,
   input  wire       pin_i,
   input  wire [1:0] mode_i,
   output reg        edge_o
);
   reg sync_a;
   reg sync_b;
   reg prev;

   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev   <= 1'b0;
         edge_o <= 1'b0;
      end else begin
         sync_a <= pin_i;
         sync_b <= sync_a;
         prev   <= sync_b;
         edge_o <= (mode_i[1] & sync_b & ~prev) | (mode_i[0] & ~sync_b & prev);
      end
   end
endmodule // edge_detect

// File: rtl/rc_tick.v
`timescale 1ns/100ps
`include "wdt_pwr_map.vh"
// divides the synchronised rc oscillator into one pulse per DIV periods
module rc_tick #(
   parameter DIV = `RC_TICK_DIV
) (
   input  wire mclk_i,
   input  wire rst_i,
   input  wire rc_clk_i,
   input  wire run_i,
   output reg  tick_o
);
   reg       sync_a;
   reg       sync_b;
   reg       prev;
   reg [7:0] count;

   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev   <= 1'b0;
         count  <= 8'h00;
         tick_o <= 1'b0;
      end else begin
         sync_a <= rc_clk_i;
         sync_b <= sync_a;
         prev   <= sync_b;
         tick_o <= 1'b0;
         if (!run_i) begin
            count <= 8'h00;
         end else if (sync_b & ~prev) begin
            if ({24'h000000, count} == DIV - 1) begin
               count  <= 8'h00;
               tick_o <= 1'b1;
            end else begin
               count <= count + 8'h01;
            end
         end
      end
   end
endmodule // rc_tick

// File: rtl/wdt_power_ctrl.v
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`include "wdt_pwr_map.vh"
module wdt_power_ctrl (
   input  wire       mclk_i,
   input  wire       rst_i,
   input  wire [7:0] addr_i,
   input  wire [7:0] wdata_i,
   input  wire       wr_i,
   input  wire       rd_i,
   output reg  [7:0] rdata_o,
   input  wire       halt_i,
   input  wire       bit_tick_i,
   input  wire       bit_clear_i,
   input  wire       timer0_ovf_i,
   input  wire       rc_clk_i,
   input  wire       ext_irq_a_i,
   input  wire       ext_irq_b_i,
   input  wire       irq_enable_i,
   output reg        cpu_run_o,
   output reg        osc_run_o,
   output reg        prescale_run_o,
   output reg        timer0_run_o,
   output reg        rc_osc_run_o,
   output reg        wdt_reset_o,
   output reg        resume_irq_o,
   output reg        irq_req_o
);
   localparam ST_RUN  = 4'b0001;
   localparam ST_STOP = 4'b0010;
   localparam ST_WAKE = 4'b0100;
   localparam ST_RCWD = 4'b1000;

   reg [3:0] state;
   reg [3:0] next_state;
   reg [7:0] clock_control_reg;
   reg [7:0] wdt_compare_reg;
   reg [7:0] edge_select_reg;
   reg [7:0] irq_flags_high;
   reg [7:0] irq_flags_low;
   reg [6:0] wdt_count;
   reg       wdt_armed;
   reg [1:0] clear_hold;
   reg [1:0] mc_div;
   reg       poll_a;
   reg       poll_b;
   reg       rst_hold;

   wire ext_edge_a;
   wire ext_edge_b;
   wire rc_tick_pulse;
   wire mc_tick;
   wire rc_mode;
   wire wdt_tick;
   wire wdt_match;
   wire any_pending;
   wire ext_pending;
   wire wr_cc;
   wire wr_wdt;
   wire wr_irq_flags_high;
   wire wr_irq_flags_low;

   function sel;
      input [7:0] a;
      input [7:0] b;
      begin
         sel = (a == b);
      end
   endfunction

   assign wr_cc   = wr_i & sel(addr_i, `ADDR_CLOCK_CONTROL);
   assign wr_wdt  = wr_i & sel(addr_i, `ADDR_WDT_COMPARE);
   assign wr_irq_flags_high = wr_i & sel(addr_i, `ADDR_IRQ_FLAGS_HIGH);
   assign wr_irq_flags_low = wr_i & sel(addr_i, `ADDR_IRQ_FLAGS_LOW);

   edge_detect u_edge_a (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .pin_i  (ext_irq_a_i),
      .mode_i (edge_select_reg[1:0]),
      .edge_o (ext_edge_a)
   );

   edge_detect u_edge_b (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .pin_i  (ext_irq_b_i),
      .mode_i (edge_select_reg[3:2]),
      .edge_o (ext_edge_b)
   );

   rc_tick #(
      .DIV (`RC_TICK_DIV)
   ) u_rc_tick (
      .mclk_i   (mclk_i),
      .rst_i    (rst_i),
      .rc_clk_i (rc_clk_i),
      .run_i    (rc_mode),
      .tick_o   (rc_tick_pulse)
   );

   assign rc_mode = clock_control_reg[`CKC_RC_WDT_ENABLE_BIT];
   assign wdt_tick = rc_mode ? rc_tick_pulse : (bit_tick_i & (state == ST_RUN));
   assign wdt_match = wdt_armed & wdt_tick & ~wdt_compare_reg[`WDT_CLEAR_BIT] & (wdt_count == wdt_compare_reg[6:0]);
   assign mc_tick = (mc_div == 2'b11);
   assign ext_pending = irq_flags_high[`IRQ_FLAGS_HIGH_EXT_A_BIT] | irq_flags_high[`IRQ_FLAGS_HIGH_EXT_B_BIT];
   assign any_pending = (|irq_flags_high) | (|irq_flags_low);

   // machine cycle divider
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         mc_div <= 2'b00;
      end else begin
         mc_div <= mc_div + 2'b01;
      end
   end

   // register writes and watchdog counter
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         clock_control_reg <= `CKC_RESET;
         wdt_compare_reg   <= `WDT_COMPARE_RESET;
         edge_select_reg   <= `EDGE_SELECT_RESET;
         wdt_count         <= 7'h00;
         wdt_armed         <= 1'b0;
         clear_hold        <= 2'b00;
      end else begin
         if (wr_cc) begin
            clock_control_reg <= wdata_i;
         end
         if (wr_i && sel(addr_i, `ADDR_EDGE_SELECT)) begin
            edge_select_reg <= wdata_i;
         end
         if (bit_clear_i) begin
            wdt_armed <= 1'b1;
         end
         if (wr_wdt) begin
            wdt_compare_reg <= wdata_i;
            if (wdata_i[`WDT_CLEAR_BIT]) begin
               wdt_count  <= 7'h00;
               clear_hold <= 2'b11;
            end
         end else begin
            // self clear after a machine cycle
            if (clear_hold != 2'b00) begin
               clear_hold <= clear_hold - 2'b01;
            end else if (wdt_compare_reg[`WDT_CLEAR_BIT]) begin
               wdt_compare_reg[`WDT_CLEAR_BIT] <= 1'b0;
            end
            if (wdt_match) begin
               wdt_count <= 7'h00;
            end else if (wdt_armed && wdt_tick && !wdt_compare_reg[`WDT_CLEAR_BIT]) begin
               wdt_count <= wdt_count + 7'h01;
            end
         end
      end
   end

   // request flags, set wins over clear
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_flags_high <= 8'h00;
         irq_flags_low  <= 8'h00;
      end else begin
         if (wr_irq_flags_high) begin
            irq_flags_high <= wdata_i;
         end
         if (wr_irq_flags_low) begin
            irq_flags_low <= wdata_i;
         end
         if (ext_edge_a) begin
            irq_flags_high[`IRQ_FLAGS_HIGH_EXT_A_BIT] <= 1'b1;
         end
         if (ext_edge_b) begin
            irq_flags_high[`IRQ_FLAGS_HIGH_EXT_B_BIT] <= 1'b1;
         end
         if (timer0_ovf_i) begin
            irq_flags_high[`IRQ_FLAGS_HIGH_TIMER0_BIT] <= 1'b1;
         end
         // interrupt on match when select is 0
         if (wdt_match && !clock_control_reg[`CKC_WDT_RST_BIT]) begin
            irq_flags_low[`IRQ_FLAGS_LOW_WDT_BIT] <= 1'b1;
         end
      end
   end

   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         poll_a    <= 1'b0;
         poll_b    <= 1'b0;
         irq_req_o <= 1'b0;
      end else begin
         if (mc_tick) begin
            poll_a <= ext_pending;
            poll_b <= poll_a & ext_pending;
         end
         irq_req_o <= (poll_b & ext_pending) | (|irq_flags_high[5:0]) | (|irq_flags_low);
      end
   end

   always @* begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (halt_i && !any_pending) begin
               if (clock_control_reg[`CKC_WAKE_BIT]) begin
                  next_state = ST_WAKE;
               end else if (clock_control_reg[`CKC_RC_WDT_ENABLE_BIT]) begin
                  next_state = ST_RCWD;
               end else begin
                  next_state = ST_STOP;
               end
            end
         end
         ST_STOP: begin
            if (ext_edge_a || ext_edge_b) begin
               next_state = ST_RUN;
            end
         end
         ST_WAKE: begin
            if (ext_edge_a || ext_edge_b || timer0_ovf_i) begin
               next_state = ST_RUN;
            end
         end
         ST_RCWD: begin
            if (ext_edge_a || ext_edge_b || wdt_match) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state          <= ST_RUN;
         cpu_run_o      <= 1'b1;
         osc_run_o      <= 1'b1;
         prescale_run_o <= 1'b1;
         timer0_run_o   <= 1'b1;
         rc_osc_run_o   <= 1'b0;
         wdt_reset_o    <= 1'b0;
         resume_irq_o   <= 1'b0;
         rst_hold       <= 1'b0;
      end else begin
         state <= next_state;
         // stop freezes cpu, pc and ports held outside
         cpu_run_o      <= (next_state == ST_RUN);
         osc_run_o      <= (next_state == ST_RUN) | (next_state == ST_WAKE);
         prescale_run_o <= (next_state == ST_RUN) | (next_state == ST_WAKE);
         timer0_run_o   <= (next_state == ST_RUN) | (next_state == ST_WAKE);
         rc_osc_run_o   <= rc_mode & (next_state != ST_WAKE);
         // resume with interrupt entry if enabled
         resume_irq_o   <= (state != ST_RUN) && (next_state == ST_RUN) && irq_enable_i;
         // reset on match when select is 1
         rst_hold       <= wdt_match & clock_control_reg[`CKC_WDT_RST_BIT];
         wdt_reset_o    <= rst_hold;
      end
   end

   // read port
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= 8'h00;
         if (rd_i) begin
            case (addr_i)
               `ADDR_CLOCK_CONTROL: begin
                  rdata_o <= clock_control_reg;
               end
               `ADDR_WDT_COMPARE: begin
                  rdata_o <= wdt_compare_reg;
               end
               `ADDR_IRQ_FLAGS_HIGH: begin
                  rdata_o <= irq_flags_high;
               end
               `ADDR_IRQ_FLAGS_LOW: begin
                  rdata_o <= irq_flags_low;
               end
               `ADDR_EDGE_SELECT: begin
                  rdata_o <= edge_select_reg;
               end
               `ADDR_WDT_COUNT: begin
                  rdata_o <= {1'b0, wdt_count};
               end
               `ADDR_PWR_STATUS: begin
                  rdata_o <= {3'b000, wdt_armed, state};
               end
               default: begin
                  rdata_o <= 8'h00;
               end
            endcase
         end
      end
   end
endmodule // wdt_power_ctrl

// File: rtl/wdt_pwr_map.vh
`ifndef WDT_PWR_MAP_VH
`define WDT_PWR_MAP_VH
// register byte addresses
`define ADDR_CLOCK_CONTROL    8'hEC
`define ADDR_WDT_COMPARE      8'hED
`define ADDR_IRQ_FLAGS_HIGH   8'hE4
`define ADDR_IRQ_FLAGS_LOW    8'hE5
`define ADDR_EDGE_SELECT      8'hE6
`define ADDR_WDT_COUNT        8'hEE
`define ADDR_PWR_STATUS       8'hEF
// clock control fields
`define CKC_WAKE_BIT          6
`define CKC_RC_WDT_ENABLE_BIT         5
`define CKC_WDT_RST_BIT       4
`define CKC_RESET             8'h00
// compare register fields
`define WDT_CLEAR_BIT         7
`define WDT_COMPARE_RESET     8'h7F
// irq_flags_high and irq_flags_low fields
`define IRQ_FLAGS_HIGH_EXT_A_BIT        7
`define IRQ_FLAGS_HIGH_EXT_B_BIT        6
`define IRQ_FLAGS_HIGH_TIMER0_BIT       5
`define IRQ_FLAGS_LOW_WDT_BIT          1
// edge select fields: [1:0] ext_irq_a, [3:2] ext_irq_b; 01 fall, 10 rise, 11 both
`define EDGE_SELECT_RESET     8'h00
// timing
`define RC_TICK_DIV           256
`define MACHINE_CYCLE_CLKS    4
`define EXT_IRQ_LATENCY_MC    12
`endif

// File: verif/rc_osc_model.sv
`timescale 1ns/100ps
module rc_osc_model #(
   parameter HALF = 20
) (
   input  logic run_i,
   output logic rc_clk_o
);
   initial rc_clk_o = 1'b0;
   always begin
      #(HALF);
      rc_clk_o = run_i ? ~rc_clk_o : 1'b0;
   end
endmodule // rc_osc_model

// File: verif/watchdog_power_saving_bench.sv
`timescale 1ns/100ps
module watchdog_power_saving_bench;
   logic       mclk_i = 0, rst_i = 1, wr = 0, rd = 0, irq_en = 0, pa = 0, pb = 0;
   logic [7:0] addr = 0, wdata = 0, rdata;
   logic [3:0] pul = 0;
   logic       cpu, osc, pre, t0r, rco, wrst, res, irq, rc_clk, saw_res = 0, saw_rst = 0;
   int         n_mismatch = 0, compares = 0;
   typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   row_t rows [8] = '{'{1'h0, 8'hEC, 8'h00, 8'h00}, '{1'h0, 8'hED, 8'h00, 8'h7F},
      '{1'h0, 8'hE6, 8'h00, 8'h00}, '{1'h0, 8'hE5, 8'h00, 8'h00}, '{1'h0, 8'h10, 8'h00, 8'h00},
      '{1'h1, 8'hE6, 8'h0F, 8'h0F}, '{1'h1, 8'h10, 8'h55, 8'h00}, '{1'h1, 8'hEC, 8'h10, 8'h10}};
   always #2.5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      if (res) saw_res <= 1'b1;
      if (wrst) saw_rst <= 1'b1;
   end
   wdt_power_ctrl dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .halt_i(pul[0]), .bit_tick_i(pul[1]), .bit_clear_i(pul[2]),
      .timer0_ovf_i(pul[3]), .rc_clk_i(rc_clk), .ext_irq_a_i(pa), .ext_irq_b_i(pb),
      .irq_enable_i(irq_en), .cpu_run_o(cpu), .osc_run_o(osc), .prescale_run_o(pre),
      .timer0_run_o(t0r), .rc_osc_run_o(rco), .wdt_reset_o(wrst), .resume_irq_o(res), .irq_req_o(irq));
   rc_osc_model rc_u (.run_i(rco), .rc_clk_o(rc_clk));
   task end_sim;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task wr_t(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge mclk_i);
      wr <= 1'b0;
   endtask
   task rd_t(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      addr <= a; rd <= 1'b1;
      @(posedge mclk_i);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task pulse(input int k);
      @(posedge mclk_i);
      pul <= 4'h1 << k;
      @(posedge mclk_i);
      pul <= 4'h0;
   endtask
   task wait_run;
      for (int i = 0; i < 400 && cpu !== 1'b1; i++) cyc(1);
      if (cpu !== 1'b1) begin
         n_mismatch++;
         end_sim;
      end
   endtask
   initial begin
      #100000 n_mismatch++;
      end_sim;
   end
   initial begin
      repeat (16) @(posedge mclk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].w) wr_t(rows[i].a, rows[i].d);
         rd_t(rows[i].a, rows[i].e);
      end
      wr_t(8'hEC, 8'h00);
      wr_t(8'hED, 8'h02);
      pulse(1); pulse(1); rd_t(8'hE5, 8'h00);
      pulse(2); pulse(1); rd_t(8'hE5, 8'h00);
      wr_t(8'hED, 8'h82); cyc(6); rd_t(8'hED, 8'h02);
      pulse(1); rd_t(8'hE5, 8'h00);
      pulse(1); rd_t(8'hEE, 8'h02);
      pulse(1); rd_t(8'hE5, 8'h02);
      wr_t(8'hE5, 8'h00); wr_t(8'hEC, 8'h10);
      pulse(1); pulse(1); cyc(3); chk(saw_rst, 8'h00);
      pulse(1); cyc(4); chk(saw_rst, 8'h01);
      rd_t(8'hE5, 8'h00);
      pa <= 1'b1; wr_t(8'hEC, 8'h00); wr_t(8'hE5, 8'h00);
      for (int m = 1; m < 4; m++) begin
         wr_t(8'hE6, m[7:0]); wr_t(8'hE4, 8'h00);
         pa <= 1'b0; cyc(8); rd_t(8'hE4, m[0] ? 8'h80 : 8'h00);
         wr_t(8'hE4, 8'h00);
         pa <= 1'b1; cyc(8); rd_t(8'hE4, m[1] ? 8'h80 : 8'h00);
      end
      wr_t(8'hE4, 8'h20); pulse(0); cyc(3); chk(cpu, 8'h01); chk(irq, 8'h01);
      // software clears both flag registers first
      wr_t(8'hE4, 8'h00); wr_t(8'hE5, 8'h00); wr_t(8'hE6, 8'h02);
      pa <= 1'b0; irq_en <= 1'b1; cyc(8); wr_t(8'hE4, 8'h00);
      pulse(0); cyc(2); chk({cpu, osc, pre, t0r, rco}, 8'h00);
      pa <= 1'b1; wait_run; cyc(2); chk(saw_res, 8'h01);
      wr_t(8'hE4, 8'h00); wr_t(8'hEC, 8'h60);
      pulse(0); cyc(2); chk({cpu, osc, pre, t0r, rco}, 8'h0E);
      pulse(3); wait_run; chk(cpu, 8'h01);
      wr_t(8'hE4, 8'h00); wr_t(8'hEC, 8'h20); wr_t(8'hE6, 8'h08);
      pulse(0); cyc(2); chk({cpu, osc, pre, t0r, rco}, 8'h01);
      pb <= 1'b1; wait_run; chk(cpu, 8'h01);
      wr_t(8'hE4, 8'h00); wr_t(8'hEC, 8'h00);
      pulse(0); cyc(2); chk(cpu, 8'h00);
      rst_i <= 1'b1; cyc(2); chk({cpu, osc, pre, t0r, rco}, 8'h1E);
      rst_i <= 1'b0; rd_t(8'hEF, 8'h01);
      rd_t(8'hED, 8'h7F); rd_t(8'hE6, 8'h00);
      end_sim;
   end
endmodule // watchdog_power_saving_bench

// File: verif/wdt_power_props.sv
`timescale 1ns/100ps
module wdt_power_props (
   input logic       mclk_i,
   input logic       rst_i,
   input logic       rd_i,
   input logic [7:0] rdata_o,
   input logic       halt_i,
   input logic       timer0_ovf_i,
   input logic       irq_enable_i,
   input logic       cpu_run_o,
   input logic       osc_run_o,
   input logic       prescale_run_o,
   input logic       timer0_run_o,
   input logic       wdt_reset_o,
   input logic       resume_irq_o,
   input logic       irq_req_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data not idle");
   AST_HALT_ENTER: assert property (halt_i && cpu_run_o && !irq_req_o |-> ##2 !cpu_run_o)
      else $error("halt not entered");
   AST_HALT_PEND: assert property (halt_i && cpu_run_o && irq_req_o |-> ##1 cpu_run_o ##1 cpu_run_o)
      else $error("halt taken with pending flag");
   AST_STOP_ALL: assert property (!osc_run_o |-> !cpu_run_o && !prescale_run_o && !timer0_run_o)
      else $error("logic runs without oscillator");
   AST_T0_OSC: assert property (timer0_run_o |-> osc_run_o && prescale_run_o)
      else $error("timer0 runs without clock");
   AST_RST_PULSE: assert property (wdt_reset_o |=> !wdt_reset_o)
      else $error("reset request too long");
   AST_RESUME_IE: assert property (resume_irq_o |-> $past(irq_enable_i))
      else $error("interrupt entry while disabled");
   AST_T0_WAKE: assert property (!cpu_run_o && osc_run_o && timer0_ovf_i |-> ##[1:4] cpu_run_o)
      else $error("timer0 did not wake cpu");
endmodule // wdt_power_props

bind wdt_power_ctrl wdt_power_props props_u (
   .mclk_i(mclk_i), .rst_i(rst_i), .rd_i(rd_i), .rdata_o(rdata_o), .halt_i(halt_i),
   .timer0_ovf_i(timer0_ovf_i), .irq_enable_i(irq_enable_i), .cpu_run_o(cpu_run_o),
   .osc_run_o(osc_run_o), .prescale_run_o(prescale_run_o), .timer0_run_o(timer0_run_o),
   .wdt_reset_o(wdt_reset_o), .resume_irq_o(resume_irq_o), .irq_req_o(irq_req_o));
